// ---- hw/tcc_pkg.sv ----
// Constants, register map and carrier types of the 16-bit timer counter core.
// Assumes one system clock and a classic Wishbone master with 8-bit register data.
package tcc_pkg;

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam int         ADDR_W        = 8;
  localparam logic [7:0] OFS_CTRL_A    = 8'h00;
  localparam logic [7:0] OFS_CTRL_B    = 8'h04;
  localparam logic [7:0] OFS_COUNT_LO  = 8'h08;
  localparam logic [7:0] OFS_COUNT_HI  = 8'h0c;
  localparam logic [7:0] OFS_CAPT_LO   = 8'h10;
  localparam logic [7:0] OFS_CAPT_HI   = 8'h14;
  localparam logic [7:0] OFS_CMPA_LO   = 8'h18;
  localparam logic [7:0] OFS_CMPA_HI   = 8'h1c;
  localparam logic [7:0] OFS_CMPB_LO   = 8'h20;
  localparam logic [7:0] OFS_CMPB_HI   = 8'h24;
  localparam logic [7:0] OFS_FLAGS     = 8'h28;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h2c;
  localparam logic [7:0] OFS_CMP_CTRL  = 8'h30;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_OVF      = 0;
  localparam int BIT_CAPT     = 5;
  localparam int BIT_CMP_SEL  = 2;
  localparam int BIT_CMP_OUT  = 5;
  localparam int BIT_EDGE_SEL = 6;
  localparam int BIT_FILT_EN  = 7;
  localparam int CS_LSB       = 0;
  localparam int WGM_HI_LSB   = 3;
  localparam int WGM_LO_LSB   = 0;

  // ****************************************************************
  // Counting constants
  // ****************************************************************
  localparam logic [15:0] TOP_8BIT   = 16'h00ff;
  localparam logic [15:0] TOP_9BIT   = 16'h01ff;
  localparam logic [15:0] TOP_10BIT  = 16'h03ff;
  localparam logic [15:0] TOP_MAX    = 16'hffff;
  localparam logic [15:0] BOTTOM_VAL = 16'h0000;
  localparam int          FILT_LEN   = 4;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} tcc_dir_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tcc_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } tcc_wb_rsp_t;

  typedef struct packed {
    logic [15:0] count;
    logic [7:0]  temp;
    logic [15:0] capture;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic        cmp_sel;
    tcc_dir_t    dir;
    logic        ovf_flag;
    logic        cap_flag;
    logic        ovf_ie;
    logic        cap_ie;
    logic [1:0]  ext_sync;
    logic        ext_prev;
    logic [1:0]  pin_sync;
    logic [1:0]  cmp_sync;
    logic [3:0]  filt_shift;
    logic        filt_out;
    logic        det_prev;
    logic        ack;
    logic [31:0] dat;
  } tcc_state_t;

  localparam tcc_state_t STATE_RST = '0;

endpackage

// ---- hw/tcc_core.sv ----
// 16-bit timer counter with shared high-byte latch, clock select and input capture.
// Assumes a classic Wishbone master on mclk and prescaler taps from the same clock.
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ps
module tcc_core (
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  input  wire tcc_pkg::tcc_wb_req_t wb_req,
  output tcc_pkg::tcc_wb_rsp_t     wb_rsp,
  input  wire logic [3:0]          presc_taps,
  input  wire logic                external_count_pin,
  input  wire logic                capture_pin,
  input  wire logic                comparator_output,
  input  wire logic                ovf_irq_ack,
  input  wire logic                cap_irq_ack,
  output logic                     ovf_irq,
  output logic                     cap_irq,
  output logic                     count_bottom,
  output logic                     count_top,
  output logic [15:0]              compare_value_a,
  output logic [15:0]              compare_value_b,
  output logic [3:0]               waveform_mode_select
);
  import tcc_pkg::*;

  // ****************************************************************
  // State and decoded controls
  // ****************************************************************
  tcc_state_t  state_reg;
  tcc_state_t  state_next;
  logic [3:0]  wgm;
  logic [2:0]  clock_source_select;
  logic [15:0] top_val;
  logic        dual_slope;
  logic        ctc_mode;
  logic        icr_top;
  logic        timer_tick;
  logic        ext_rise;
  logic        ext_fall;
  logic        cap_src;
  logic        det_in;
  logic        capture_trig;
  logic        bus_req;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  wdat;
  logic [7:0]  rd_byte;
  logic        wr_count_lo;
  logic        rd_count_lo;
  logic        rd_capt_lo;
  logic        ovf_set;
  logic        ovf_clr;
  logic        cap_clr;
  logic [3:0]  filt_win;

  assign wgm = {state_reg.ctrl_b[WGM_HI_LSB +: 2], state_reg.ctrl_a[WGM_LO_LSB +: 2]};
  assign clock_source_select = state_reg.ctrl_b[CS_LSB +: 3];
  assign waveform_mode_select = wgm;
  assign compare_value_a = state_reg.cmp_a;
  assign compare_value_b = state_reg.cmp_b;

  always_comb begin
    case (wgm)
      4'h1, 4'h5: top_val = TOP_8BIT;
      4'h2, 4'h6: top_val = TOP_9BIT;
      4'h3, 4'h7: top_val = TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: top_val = state_reg.cmp_a;
      4'h8, 4'ha, 4'hc, 4'he: top_val = state_reg.capture;
      default: top_val = TOP_MAX;
    endcase
  end

  assign dual_slope = (wgm inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
  assign ctc_mode   = (wgm == 4'h4) || (wgm == 4'hc);
  assign icr_top    = (wgm inside {4'h8, 4'ha, 4'hc, 4'he});

  assign count_bottom = (state_reg.count == BOTTOM_VAL);
  assign count_top    = (state_reg.count == top_val);

  // ****************************************************************
  // Tick selection
  // ****************************************************************
  // The external pin is only read after its second sync stage.
  assign ext_rise = state_reg.ext_sync[1] & ~state_reg.ext_prev;
  assign ext_fall = ~state_reg.ext_sync[1] & state_reg.ext_prev;

  always_comb begin
    case (clock_source_select)
      3'h0: timer_tick = 1'b0;
      3'h1: timer_tick = 1'b1;
      3'h2: timer_tick = presc_taps[0];
      3'h3: timer_tick = presc_taps[1];
      3'h4: timer_tick = presc_taps[2];
      3'h5: timer_tick = presc_taps[3];
      3'h6: timer_tick = ext_fall;
      default: timer_tick = ext_rise;
    endcase
  end

  // ****************************************************************
  // Capture path
  // ****************************************************************
  // Switching the source can look like an edge; software clears the flag after.
  assign cap_src = state_reg.cmp_sel ? state_reg.cmp_sync[1] : state_reg.pin_sync[1];
  // The window holds the present sample and three older ones, so the delay is exactly four.
  assign filt_win = {state_reg.filt_shift[2:0], cap_src};
  assign det_in  = state_reg.ctrl_b[BIT_FILT_EN] ? state_reg.filt_out : cap_src;
  assign capture_trig = ~icr_top &&
    (state_reg.ctrl_b[BIT_EDGE_SEL] ? (det_in & ~state_reg.det_prev)
                                    : (~det_in & state_reg.det_prev));

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign bus_req = wb_req.cyc & wb_req.stb & ~state_reg.ack;
  assign bus_wr  = bus_req & wb_req.we & wb_req.sel[0];
  assign bus_rd  = bus_req & ~wb_req.we;
  assign wdat    = wb_req.dat[7:0];
  assign wr_count_lo = bus_wr && (wb_req.adr == OFS_COUNT_LO);
  assign rd_count_lo = bus_rd && (wb_req.adr == OFS_COUNT_LO);
  assign rd_capt_lo  = bus_rd && (wb_req.adr == OFS_CAPT_LO);

  always_comb begin
    if (wb_req.adr == OFS_CTRL_A) begin
      rd_byte = state_reg.ctrl_a;
    end else if (wb_req.adr == OFS_CTRL_B) begin
      rd_byte = state_reg.ctrl_b;
    end else if (wb_req.adr == OFS_COUNT_LO) begin
      rd_byte = state_reg.count[7:0];
    end else if (wb_req.adr == OFS_COUNT_HI || wb_req.adr == OFS_CAPT_HI) begin
      rd_byte = state_reg.temp;
    end else if (wb_req.adr == OFS_CAPT_LO) begin
      rd_byte = state_reg.capture[7:0];
    end else if (wb_req.adr == OFS_CMPA_LO) begin
      rd_byte = state_reg.cmp_a[7:0];
    end else if (wb_req.adr == OFS_CMPA_HI) begin
      rd_byte = state_reg.cmp_a[15:8];
    end else if (wb_req.adr == OFS_CMPB_LO) begin
      rd_byte = state_reg.cmp_b[7:0];
    end else if (wb_req.adr == OFS_CMPB_HI) begin
      rd_byte = state_reg.cmp_b[15:8];
    end else if (wb_req.adr == OFS_FLAGS) begin
      rd_byte = 8'h00;
      rd_byte[BIT_OVF]  = state_reg.ovf_flag;
      rd_byte[BIT_CAPT] = state_reg.cap_flag;
    end else if (wb_req.adr == OFS_IRQ_EN) begin
      rd_byte = 8'h00;
      rd_byte[BIT_OVF]  = state_reg.ovf_ie;
      rd_byte[BIT_CAPT] = state_reg.cap_ie;
    end else if (wb_req.adr == OFS_CMP_CTRL) begin
      rd_byte = 8'h00;
      rd_byte[BIT_CMP_SEL] = state_reg.cmp_sel;
      rd_byte[BIT_CMP_OUT] = state_reg.cmp_sync[1];
    end else begin
      rd_byte = 8'h00;
    end
  end

  assign ovf_clr = ovf_irq_ack | (bus_wr && wb_req.adr == OFS_FLAGS && wdat[BIT_OVF]);
  assign cap_clr = cap_irq_ack | (bus_wr && wb_req.adr == OFS_FLAGS && wdat[BIT_CAPT]);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    ovf_set = 1'b0;
    if (clk_en) begin
      // Synchronisers: the first stage feeds only the second.
      state_next.ext_sync = {state_reg.ext_sync[0], external_count_pin};
      state_next.pin_sync = {state_reg.pin_sync[0], capture_pin};
      state_next.cmp_sync = {state_reg.cmp_sync[0], comparator_output};
      state_next.ext_prev = state_reg.ext_sync[1];
      state_next.filt_shift = {state_reg.filt_shift[2:0], cap_src};
      if (&filt_win) begin
        state_next.filt_out = 1'b1;
      end else if (~|filt_win) begin
        state_next.filt_out = 1'b0;
      end
      if (!icr_top) begin
        state_next.det_prev = det_in;
      end
      // Counter: a bus write wins over any count in the same cycle.
      if (wr_count_lo) begin
        state_next.count = {state_reg.temp, wdat};
      end else if (timer_tick) begin
        if (!dual_slope) begin
          if (state_reg.count == top_val) begin
            state_next.count = BOTTOM_VAL;
          end else begin
            state_next.count = state_reg.count + 16'h0001;
          end
          ovf_set = ctc_mode ? (state_reg.count == TOP_MAX)
                             : (state_reg.count == top_val);
        end else if (state_reg.dir == DIR_UP) begin
          if (state_reg.count >= top_val) begin
            state_next.dir = DIR_DOWN;
            state_next.count = state_reg.count - 16'h0001;
          end else begin
            state_next.count = state_reg.count + 16'h0001;
          end
        end else begin
          if (state_reg.count == BOTTOM_VAL) begin
            state_next.dir = DIR_UP;
            state_next.count = state_reg.count + 16'h0001;
            ovf_set = 1'b1;
          end else begin
            state_next.count = state_reg.count - 16'h0001;
          end
        end
      end
      // Flags: a hardware set in the clear cycle is kept.
      state_next.ovf_flag = (state_reg.ovf_flag & ~ovf_clr) | ovf_set;
      state_next.cap_flag = (state_reg.cap_flag & ~cap_clr) | capture_trig;
      if (rd_count_lo) begin
        state_next.temp = state_reg.count[15:8];
      end else if (rd_capt_lo) begin
        state_next.temp = state_reg.capture[15:8];
      end
      if (bus_wr) begin
        if (wb_req.adr == OFS_CTRL_A) begin
          state_next.ctrl_a = wdat;
        end else if (wb_req.adr == OFS_CTRL_B) begin
          state_next.ctrl_b = wdat;
        end else if (wb_req.adr == OFS_COUNT_HI || wb_req.adr == OFS_CAPT_HI ||
                     wb_req.adr == OFS_CMPA_HI || wb_req.adr == OFS_CMPB_HI) begin
          state_next.temp = wdat;
        end else if (wb_req.adr == OFS_CMPA_LO) begin
          state_next.cmp_a = {state_reg.temp, wdat};
        end else if (wb_req.adr == OFS_CMPB_LO) begin
          state_next.cmp_b = {state_reg.temp, wdat};
        end else if (wb_req.adr == OFS_IRQ_EN) begin
          state_next.ovf_ie = wdat[BIT_OVF];
          state_next.cap_ie = wdat[BIT_CAPT];
        end else if (wb_req.adr == OFS_CMP_CTRL) begin
          state_next.cmp_sel = wdat[BIT_CMP_SEL];
        end
      end
      // Capture wins over a bus write to the capture register.
      if (capture_trig) begin
        state_next.capture = state_reg.count;
      end else if (bus_wr && icr_top && wb_req.adr == OFS_CAPT_LO) begin
        state_next.capture = {state_reg.temp, wdat};
      end
      state_next.ack = bus_req;
      if (bus_req) begin
        state_next.dat = {24'h000000, rd_byte};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_rsp.ack = state_reg.ack;
  assign wb_rsp.dat = state_reg.dat;
  assign ovf_irq = state_reg.ovf_flag & state_reg.ovf_ie;
  assign cap_irq = state_reg.cap_flag & state_reg.cap_ie;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  ack_single_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("Ack held longer than one cycle.");
  ack_follows_a: assert property (clk_en && bus_req |=> wb_rsp.ack)
    else $error("Request not acknowledged next cycle.");
  count_write_a: assert property (clk_en && wr_count_lo |=>
    state_reg.count == {$past(state_reg.temp), $past(wdat)})
    else $error("Counter low write did not load latch and byte.");
  write_wins_a: assert property (clk_en && wr_count_lo && timer_tick |=>
    state_reg.count[7:0] == $past(wdat))
    else $error("Count tick overrode a counter write.");
  stopped_a: assert property (clk_en && clock_source_select == 3'h0 && !wr_count_lo
    |=> $stable(state_reg.count))
    else $error("Counter moved with no clock source.");
  latch_load_a: assert property (clk_en && rd_count_lo |=>
    state_reg.temp == $past(state_reg.count[15:8]))
    else $error("Latch not loaded on counter low read.");
  capture_copy_a: assert property (clk_en && capture_trig |=>
    state_reg.capture == $past(state_reg.count) && state_reg.cap_flag)
    else $error("Capture did not copy counter and set flag.");
  flag_set_wins_a: assert property (clk_en && capture_trig && cap_clr |=>
    state_reg.cap_flag)
    else $error("Capture event lost against a clear.");
  flag_clear_a: assert property (clk_en && cap_clr && !capture_trig |=>
    !state_reg.cap_flag && !cap_irq)
    else $error("Capture flag not cleared.");
  capt_gate_a: assert property (clk_en && !icr_top && !capture_trig |=>
    $stable(state_reg.capture))
    else $error("Capture register written outside capture-top modes.");
  no_capt_top_a: assert property (icr_top |-> !capture_trig)
    else $error("Capture fired while capture register is top.");
  filter_agree_a: assert property (clk_en && $changed(state_reg.filt_out) |->
    {$past(state_reg.filt_shift[2:0]), $past(cap_src)} == {4{state_reg.filt_out}})
    else $error("Filter changed without four agreeing samples.");
  cmp_read_a: assert property (clk_en && bus_rd && wb_req.adr == OFS_CMPA_HI
    |=> $stable(state_reg.temp) && wb_rsp.dat[7:0] == state_reg.cmp_a[15:8])
    else $error("Compare read disturbed latch or returned wrong byte.");

  capture_seen_c: cover property (clk_en && capture_trig);
  overflow_seen_c: cover property (clk_en && ovf_set);
  count_write_c: cover property (clk_en && wr_count_lo && timer_tick);
  filtered_capt_c: cover property (clk_en && capture_trig && state_reg.ctrl_b[BIT_FILT_EN]);

endmodule

// ---- bench/tcc_cpu_model.sv ----
// Wishbone master model standing in for the CPU core on the byte-wide register bus.
// Assumes the core acks every request; the bench's own timeout bounds every wait.
`timescale 1ns/1ps
module tcc_cpu_model (
  input  wire logic                 mclk,
  output tcc_pkg::tcc_wb_req_t      wb_req,
  input  wire tcc_pkg::tcc_wb_rsp_t wb_rsp
);
  import tcc_pkg::*;

  initial wb_req = '0;

  // A released bus shows the inverse of the last request, never a stale copy.
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                      output logic [7:0] rd);
    tcc_wb_req_t nx;
    @(posedge mclk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, wd}};
    do @(posedge mclk); while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat[7:0];
    nx = ~wb_req;
    nx.cyc = 1'b0;
    nx.stb = 1'b0;
    wb_req <= nx;
  endtask

  task automatic wr8(input logic [7:0] adr, input logic [7:0] d);
    logic [7:0] r;
    xfer(1'b1, adr, d, r);
  endtask

  task automatic rd8(input logic [7:0] adr, output logic [7:0] d);
    xfer(1'b0, adr, 8'h00, d);
  endtask

  // Callers never interleave two pairs, so the shared latch is never disturbed.
  task automatic wr16(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] d);
    wr8(hi, d[15:8]);
    wr8(lo, d[7:0]);
  endtask

  task automatic rd16(input logic [7:0] lo, input logic [7:0] hi, output logic [15:0] d);
    rd8(lo, d[7:0]);
    rd8(hi, d[15:8]);
  endtask
endmodule

// ---- bench/tcc_core_tb.sv ----
// Self-checking bench for the 16-bit timer counter core.
// Assumes tcc_cpu_model as bus master and a single 25 MHz clock.
`timescale 1ns/1ps
module tcc_core_tb;
  import tcc_pkg::*;
  typedef struct packed {logic [7:0] adr; logic [7:0] wd; logic [7:0] rd;} tcc_row_t;
  localparam tcc_row_t ROWS [5] = '{'{OFS_CTRL_A, 8'h5c, 8'h5c}, '{OFS_IRQ_EN, 8'h21, 8'h21},
    '{OFS_CMP_CTRL, 8'h04, 8'h04}, '{8'h3c, 8'hff, 8'h00}, '{OFS_CTRL_B, 8'h40, 8'h40}};
  logic        mclk, sys_rst, clk_en, capture_pin, comparator_output;
  logic        ovf_irq_ack, cap_irq_ack, ovf_irq, cap_irq, count_bottom, count_top;
  tcc_wb_req_t wb_req;
  tcc_wb_rsp_t wb_rsp;
  logic [15:0] compare_value_a, compare_value_b, v;
  logic [3:0]  waveform_mode_select;
  logic [7:0]  b;
  int          n_mismatch = 0, cmp_count = 0, cycles = 0, n0, n1;

  tcc_cpu_model cpu (.mclk(mclk), .wb_req(wb_req), .wb_rsp(wb_rsp));
  tcc_core dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .presc_taps(4'h0), .external_count_pin(1'b0),
    .capture_pin(capture_pin), .comparator_output(comparator_output),
    .ovf_irq_ack(ovf_irq_ack), .cap_irq_ack(cap_irq_ack), .ovf_irq(ovf_irq),
    .cap_irq(cap_irq), .count_bottom(count_bottom), .count_top(count_top),
    .compare_value_a(compare_value_a), .compare_value_b(compare_value_b),
    .waveform_mode_select(waveform_mode_select));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // The whole sequence needs fewer than a thousand cycles; this ceiling only catches hangs.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic note(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic wait_hi(ref logic s, input int lim, output int n);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  task automatic cap_edge(input logic cmp, input logic lvl, output int n);
    @(posedge mclk);
    if (cmp) comparator_output <= lvl;
    else capture_pin <= lvl;
    wait_hi(cap_irq, 20, n);
  endtask

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    capture_pin = 1'b0;
    comparator_output = 1'b0;
    ovf_irq_ack = 1'b0;
    cap_irq_ack = 1'b0;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk("bottom at reset", 16'h1, {15'h0, count_bottom});
    chk("top at reset", 16'h0, {15'h0, count_top});
    note("reset");
    foreach (ROWS[i]) begin
      cpu.wr8(ROWS[i].adr, ROWS[i].wd);
      cpu.rd8(ROWS[i].adr, b);
      chk("register readback", {8'h0, ROWS[i].rd}, {8'h0, b});
    end
    note("register table");
    cpu.wr8(OFS_CTRL_A, 8'h00);
    cpu.wr8(OFS_CMP_CTRL, 8'h00);
    cpu.wr8(OFS_CTRL_B, 8'h00);
    cpu.wr16(OFS_COUNT_LO, OFS_COUNT_HI, 16'h01ff);
    cpu.wr8(OFS_COUNT_HI, 8'h55);
    cpu.rd8(OFS_COUNT_HI, b);
    chk("latch via count hi", 16'h0055, {8'h0, b});
    cpu.rd16(OFS_COUNT_LO, OFS_COUNT_HI, v);
    chk("stopped count", 16'h01ff, v);
    cpu.wr16(OFS_CMPA_LO, OFS_CMPA_HI, 16'h1234);
    cpu.wr8(OFS_COUNT_HI, 8'haa);
    cpu.rd8(OFS_CMPA_HI, b);
    chk("compare hi direct", 16'h0012, {8'h0, b});
    cpu.rd8(OFS_COUNT_HI, b);
    chk("latch kept", 16'h00aa, {8'h0, b});
    chk("compare a port", 16'h1234, compare_value_a);
    cpu.wr8(OFS_CMPB_HI, 8'h7e);
    cpu.wr8(OFS_CMPB_LO, 8'h01);
    cpu.wr8(OFS_COUNT_LO, 8'h02);
    chk("shared hi compare", 16'h7e01, compare_value_b);
    cpu.rd16(OFS_COUNT_LO, OFS_COUNT_HI, v);
    chk("shared hi count", 16'h7e02, v);
    note("shared latch");
    cpu.wr16(OFS_COUNT_LO, OFS_COUNT_HI, 16'hffff);
    #1;
    chk("top at max", 16'h1, {15'h0, count_top});
    cpu.wr16(OFS_COUNT_LO, OFS_COUNT_HI, 16'hfffd);
    cpu.wr8(OFS_CTRL_B, 8'h01);
    wait_hi(ovf_irq, 40, n0);
    chk("overflow irq", 16'h1, {15'h0, ovf_irq});
    cpu.wr16(OFS_COUNT_LO, OFS_COUNT_HI, 16'h1000);
    cpu.rd16(OFS_COUNT_LO, OFS_COUNT_HI, v);
    chk("write beats count", 16'h1000, (v >= 16'h1000 && v < 16'h1010) ? 16'h1000 : v);
    @(posedge mclk);
    ovf_irq_ack <= 1'b1;
    @(posedge mclk);
    ovf_irq_ack <= 1'b0;
    #1;
    chk("overflow ack", 16'h0, {15'h0, ovf_irq});
    cpu.wr8(OFS_CTRL_B, 8'h00);
    cpu.wr8(OFS_CTRL_A, 8'h01);
    cpu.wr16(OFS_COUNT_LO, OFS_COUNT_HI, 16'h00f0);
    cpu.wr8(OFS_CTRL_B, 8'h01);
    wait_hi(count_top, 40, n0);
    chk("dual slope top", 16'h1, {15'h0, count_top});
    wait_hi(count_bottom, 600, n1);
    chk("down to bottom", 16'h1, (n1 > 250 && n1 < 262) ? 16'h1 : 16'(n1));
    wait_hi(ovf_irq, 4, n0);
    chk("overflow at bottom", 16'h1, {15'h0, ovf_irq});
    cpu.wr8(OFS_CTRL_B, 8'h00);
    cpu.wr8(OFS_CTRL_A, 8'h00);
    cpu.wr8(OFS_FLAGS, 8'h01);
    note("counting");
    cpu.wr16(OFS_COUNT_LO, OFS_COUNT_HI, 16'h4321);
    cpu.wr8(OFS_CTRL_B, 8'h40);
    cap_edge(1'b0, 1'b1, n0);
    chk("capture on rise", 16'h1, {15'h0, cap_irq});
    cpu.rd16(OFS_CAPT_LO, OFS_CAPT_HI, v);
    chk("captured count", 16'h4321, v);
    cpu.rd8(OFS_FLAGS, b);
    chk("capture flag", 16'h0020, {8'h0, b & 8'h20});
    cpu.wr8(OFS_FLAGS, 8'h20);
    #1;
    chk("flag write clear", 16'h0, {15'h0, cap_irq});
    cap_edge(1'b0, 1'b0, n1);
    chk("fall ignored", 16'h0, {15'h0, cap_irq});
    cpu.wr8(OFS_CTRL_B, 8'hc0);
    cap_edge(1'b0, 1'b1, n1);
    chk("filter delay", 16'h4, 16'(n1 - n0));
    cpu.wr8(OFS_CTRL_B, 8'h80);
    cpu.wr8(OFS_FLAGS, 8'h20);
    @(posedge mclk);
    capture_pin <= 1'b0;
    repeat (3) @(posedge mclk);
    capture_pin <= 1'b1;
    repeat (20) @(posedge mclk);
    #1;
    chk("short pulse filtered", 16'h0, {15'h0, cap_irq});
    cap_edge(1'b0, 1'b0, n1);
    chk("filtered fall", 16'h1, {15'h0, cap_irq});
    @(posedge mclk);
    cap_irq_ack <= 1'b1;
    @(posedge mclk);
    cap_irq_ack <= 1'b0;
    #1;
    chk("irq ack clear", 16'h0, {15'h0, cap_irq});
    note("capture");
    cpu.wr8(OFS_CTRL_B, 8'h40);
    cpu.wr8(OFS_CMP_CTRL, 8'h04);
    cpu.wr8(OFS_FLAGS, 8'h20);
    cap_edge(1'b1, 1'b1, n0);
    chk("comparator capture", 16'h1, {15'h0, cap_irq});
    cpu.wr8(OFS_CMP_CTRL, 8'h00);
    cpu.wr8(OFS_FLAGS, 8'h20);
    note("comparator");
    cpu.wr8(OFS_CTRL_B, 8'h58);
    cpu.wr16(OFS_CAPT_LO, OFS_CAPT_HI, 16'h0abc);
    chk("mode field", 16'h000c, {12'h0, waveform_mode_select});
    cap_edge(1'b0, 1'b1, n0);
    chk("capture gated", 16'h0, {15'h0, cap_irq});
    cap_edge(1'b0, 1'b0, n0);
    cpu.rd16(OFS_CAPT_LO, OFS_CAPT_HI, v);
    chk("capture as top", 16'h0abc, v);
    cpu.wr8(OFS_CTRL_B, 8'h40);
    cpu.wr8(OFS_CAPT_LO, 8'h00);
    cpu.rd16(OFS_CAPT_LO, OFS_CAPT_HI, v);
    chk("capture write refused", 16'h0abc, v);
    note("capture top");
    report_and_stop();
  end
endmodule
